/* verilog/cpu_ctl_pkg.sv */
// constants and types for the processor control-input logic
package cpu_ctl_pkg;
   localparam int unsigned  RESET_MIN_CYC  = 16;  // reset must exceed this
   localparam int unsigned  INIT_CYC       = 38;  // init cycles before fetch
   localparam int unsigned  ALIGN_EDGES    = 2;   // edges to phase alignment
   localparam logic [7:0]   NMI_VECTOR     = 8'h02;
   localparam logic [4:0]   RST_CNT_MAX    = 5'h1f;
   localparam logic [4:0]   RST_CNT_LONG   = 5'(RESET_MIN_CYC + 1);
   localparam logic [5:0]   INIT_LAST      = 6'(INIT_CYC - 1);
   localparam logic [1:0]   ALIGN_LOAD     = 2'(ALIGN_EDGES - 1);
   localparam logic [23:0]  ADDR_RESET     = 24'hffffff;

   // bus pins driven by the core, also the pin image
   typedef struct packed {
      logic        status0;
      logic        status1;
      logic        mem_io;
      logic        code_intack_select;
      logic        lock_n;
      logic        bhe_n;
      logic [23:0] addr;
   } core_bus_t;

   localparam core_bus_t BUS_RESET = '{status0: 1'b1, status1: 1'b1,
                                       mem_io: 1'b0, code_intack_select: 1'b0,
                                       lock_n: 1'b1, bhe_n: 1'b1,
                                       addr: ADDR_RESET};

   // reset sequencer, gray along reset -> init -> run
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_INIT  = 2'b01,
      ST_RUN   = 2'b11
   } seq_state_t;
endpackage : cpu_ctl_pkg

/* verilog/sync2.sv */
// two-flop synchroniser with a chosen reset level
`timescale 1ns/1ps
module sync2 #(
   parameter int unsigned       WIDTH = 1,
   parameter logic [WIDTH-1:0]  INIT  = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= INIT;
         q      <= INIT;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : sync2

/* verilog/cpu_control_input_logic.sv */
// reset sequencing, nmi detect and coprocessor handshake of the processor
`timescale 1ns/1ps
module cpu_control_input_logic
   import cpu_ctl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sys_reset,
   input  wire logic        nonmaskable_irq,
   input  wire logic        hold_req,
   input  wire logic        ext_operand_req,
   input  wire logic        busy_n,
   input  wire logic        error_n,
   input  wire core_bus_t   core_bus,
   input  wire logic [15:0] core_data,
   input  wire logic        core_data_drive,
   input  wire logic        core_nmi_ack,
   input  wire logic        core_op_active,
   input  wire logic        core_wait_exec,
   output core_bus_t        pin_bus,
   output logic             bus_oe,
   output logic [15:0]      data_out,
   output logic             data_oe,
   output logic             hold_ack,
   output logic             ext_operand_ack_n,
   output logic             op_xfer_req,
   output logic             nmi_pending,
   output logic [7:0]       nmi_vector,
   output logic             exec_stall,
   output logic             pext_err_irq,
   output logic             core_enable,
   output logic             first_fetch,
   output logic             proc_clk
);
   // synchronised pin inputs
   logic            reset_s;
   logic            nmi_s;
   logic            hold_s;
   logic            opreq_s;
   logic            busy_s_n;
   logic            error_s_n;

   // sequencer state
   seq_state_t      state_r;
   seq_state_t      state_nxt;
   logic [4:0]      rst_cnt_r;
   logic [4:0]      rst_cnt_nxt;
   logic            armed_r;
   logic            armed_nxt;
   logic [5:0]      init_cnt_r;
   logic [5:0]      init_cnt_nxt;
   logic            first_fetch_r;
   logic            reset_d_r;
   logic [1:0]      align_r;
   logic [1:0]      align_nxt;
   logic            proc_clk_r;
   logic            proc_clk_nxt;

   // event and pin state
   logic            nmi_d_r;
   logic            nmi_pend_r;
   logic            nmi_pend_nxt;
   logic [7:0]      nmi_vec_r;
   logic            err_irq_r;
   logic            hold_ack_r;
   logic            ack_n_r;
   core_bus_t       pin_bus_r;
   logic [15:0]     data_r;

   // decode wires
   wire st_reset   = (state_r == ST_RESET);
   wire st_init    = (state_r == ST_INIT);
   wire st_run     = (state_r == ST_RUN);
   wire long_rst   = (rst_cnt_r >= RST_CNT_LONG);
   wire init_last  = st_init && (init_cnt_r == INIT_LAST);
   wire reset_rise = reset_s && !reset_d_r;
   wire nmi_rise   = nmi_s && !nmi_d_r;
   wire busy_act   = !busy_s_n;
   wire error_act  = !error_s_n;
   wire clear_core = st_reset && !reset_s && (long_rst || armed_r);

   // busy and error idle high, so undriven pins read inactive
   sync2 #(.WIDTH(2), .INIT(2'b11)) u_sync_pext (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({busy_n, error_n}),
      .q     ({busy_s_n, error_s_n})
   );

   // remaining pins are sampled twice; none is trusted to be synchronous
   sync2 #(.WIDTH(4), .INIT(4'h1)) u_sync_ctl (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({nonmaskable_irq, hold_req, ext_operand_req, sys_reset}),
      .q     ({nmi_s, hold_s, opreq_s, reset_s})
   );

   // reset sequencer: short pulses only force pins unless armed_r is set, long ones reinitialise
   always_comb begin
      state_nxt    = state_r;
      rst_cnt_nxt  = rst_cnt_r;
      armed_nxt    = armed_r;
      init_cnt_nxt = init_cnt_r;
      unique case (state_r)
         ST_RESET: begin
            if (reset_s) begin
               if (rst_cnt_r != RST_CNT_MAX) begin
                  rst_cnt_nxt = rst_cnt_r + 5'h01;
               end
            end else if (long_rst || armed_r) begin
               state_nxt    = ST_INIT;
               armed_nxt    = 1'b0;
               init_cnt_nxt = '0;
            end else begin
               state_nxt = ST_RUN;
            end
         end
         ST_INIT: begin
            if (reset_s) begin
               state_nxt   = ST_RESET;
               rst_cnt_nxt = 5'h01;
               armed_nxt   = 1'b1;   // init was not finished
            end else if (init_last) begin
               state_nxt = ST_RUN;
            end else begin
               init_cnt_nxt = init_cnt_r + 6'h01;
            end
         end
         ST_RUN: begin
            if (reset_s) begin
               state_nxt   = ST_RESET;
               rst_cnt_nxt = 5'h01;
            end
         end
         default: begin
            state_nxt = ST_RESET;
            armed_nxt = 1'b1;
         end
      endcase
   end

   // falling edge also passes the two-flop sync; the state moves on the edge after reset_s drops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r       <= ST_RESET;
         rst_cnt_r     <= '0;
         armed_r       <= 1'b1;
         init_cnt_r    <= '0;
         first_fetch_r <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         rst_cnt_r     <= rst_cnt_nxt;
         armed_r       <= armed_nxt;
         init_cnt_r    <= init_cnt_nxt;
         first_fetch_r <= init_last && !reset_s;
      end
   end

   // halved clock; a reset rise forces low at the second edge
   always_comb begin
      align_nxt    = align_r;
      proc_clk_nxt = !proc_clk_r;
      if (reset_rise) begin
         align_nxt = ALIGN_LOAD;
      end else if (align_r != 2'h0) begin
         align_nxt    = align_r - 2'h1;
         proc_clk_nxt = 1'b0;
      end
   end

   // an asynchronous rise only shifts where this phase lands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_d_r  <= 1'b1;
         align_r    <= '0;
         proc_clk_r <= 1'b0;
      end else begin
         reset_d_r  <= reset_s;
         align_r    <= align_nxt;
         proc_clk_r <= proc_clk_nxt;
      end
   end

   // nmi latch: flag state never gates it, a new edge beats the ack
   assign nmi_pend_nxt = nmi_rise ||
                         (nmi_pend_r && !core_nmi_ack && !clear_core);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nmi_d_r    <= 1'b0;
         nmi_pend_r <= 1'b0;
         nmi_vec_r  <= 8'h00;
      end else begin
         nmi_d_r    <= nmi_s;
         nmi_pend_r <= nmi_pend_nxt;
         nmi_vec_r  <= nmi_pend_nxt ? NMI_VECTOR : 8'h00;
      end
   end

   // error sampled once busy has cleared at a wait
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         err_irq_r <= 1'b0;
      end else begin
         err_irq_r <= st_run && core_wait_exec &&
                      !busy_act && error_act;
      end
   end

   // pin image: bus and ack fixed outside run, core values otherwise; data and hold ack follow in every state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_bus_r  <= BUS_RESET;
         ack_n_r    <= 1'b1;
         hold_ack_r <= 1'b0;
         data_r     <= 16'h0000;
      end else begin
         pin_bus_r  <= st_run ? core_bus : BUS_RESET;
         ack_n_r    <= !(st_run && core_op_active);
         hold_ack_r <= hold_s;
         data_r     <= core_data;
      end
   end

   // request handed to the core, which runs it through its own checks
   assign op_xfer_req = st_run && opreq_s;
   // the stall drops while an interrupt waits, so it can be taken
   assign exec_stall  = st_run && core_wait_exec &&
                        busy_act && !nmi_pend_r;
   // every bus driver lets go while hold is granted
   assign bus_oe      = !hold_ack_r;
   assign data_oe     = !hold_ack_r && st_run && core_data_drive;
   assign pin_bus           = pin_bus_r;
   assign data_out          = data_r;
   assign hold_ack          = hold_ack_r;
   assign ext_operand_ack_n = ack_n_r;
   assign nmi_pending       = nmi_pend_r;
   assign nmi_vector        = nmi_vec_r;
   assign pext_err_irq      = err_irq_r;
   assign core_enable       = st_run;
   assign first_fetch       = first_fetch_r;
   assign proc_clk          = proc_clk_r;

   // checks on the driven side
   chk_nmi_vector: assert property (
      @(posedge clk) disable iff (!rst_n)
      nmi_pending |-> (nmi_vector == 8'h02))
      else $error("nmi vector is not 2 while pending");

   chk_nmi_edge: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(nmi_s) |=> nmi_pending [*1])
      else $error("nmi rising edge not latched");

   chk_nmi_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      (nmi_pending && !core_nmi_ack && !clear_core) |=> nmi_pending)
      else $error("pending nmi dropped without ack");

   chk_ack_follow: assert property (
      @(posedge clk) disable iff (!rst_n)
      (st_run && core_op_active) |=> !ext_operand_ack_n)
      else $error("operand ack missing during transfer");

   chk_req_pass: assert property (
      @(posedge clk) disable iff (!rst_n)
      op_xfer_req |-> (st_run && $past(ext_operand_req, 2)))
      else $error("operand request without synced pin");

   chk_reset_pins: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_reset |-> !data_oe ##1
      (pin_bus.addr == 24'hffffff && pin_bus.status0 &&
       pin_bus.status1 && !pin_bus.mem_io &&
       !pin_bus.code_intack_select && pin_bus.lock_n &&
       pin_bus.bhe_n && ext_operand_ack_n))
      else $error("pin levels wrong during reset");

   chk_hold_low: assert property (
      @(posedge clk) disable iff (!rst_n)
      (st_reset && !hold_s) |=> !hold_ack)
      else $error("hold_ack high in reset without hold");

   chk_float_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      hold_ack |-> (!bus_oe && !data_oe))
      else $error("drivers active during hold");

   chk_init_len: assert property (
      @(posedge clk) disable iff (!rst_n)
      ($rose(st_init) && !reset_s) ##1 (!reset_s [*8]) |->
      ##30 (first_fetch || reset_s || $past(reset_s)))
      else $error("first fetch not 38 cycles after reset");

   chk_short_rst: assert property (
      @(posedge clk) disable iff (!rst_n)
      (st_reset && !reset_s && !long_rst && !armed_r) |=>
      (st_run && !first_fetch))
      else $error("short reset pulse reinitialised");

   chk_clk_align: assert property (
      @(posedge clk) disable iff (!rst_n)
      reset_rise |-> ##2 !proc_clk)
      else $error("processor clock not aligned after reset");

   chk_clk_div: assert property (
      @(posedge clk) disable iff (!rst_n)
      (align_r == 2'h0 && !reset_rise) |=> (proc_clk != $past(proc_clk)))
      else $error("processor clock not toggling");

   chk_stall_busy: assert property (
      @(posedge clk) disable iff (!rst_n)
      (exec_stall |-> (busy_act && core_wait_exec)) and
      ((st_run && core_wait_exec && busy_act && !nmi_pending)
       |-> exec_stall))
      else $error("stall does not follow busy");

   chk_stall_irq: assert property (
      @(posedge clk) disable iff (!rst_n)
      nmi_pending |-> !exec_stall)
      else $error("stall blocks pending interrupt");

   chk_err_irq: assert property (
      @(posedge clk) disable iff (!rst_n)
      (st_run && core_wait_exec && !busy_act && error_act) |=>
      pext_err_irq)
      else $error("extension error interrupt missing");

   chk_pext_idle: assert property (
      @(posedge clk) disable iff (!rst_n)
      ($past(busy_n, 3) && $past(busy_n, 2)) |-> !busy_act)
      else $error("busy synchroniser wrong level");
endmodule : cpu_control_input_logic

/* dv/coproc_model.sv */
// far-side model: coprocessor status lines and nmi source
`timescale 1ns/1ps
module coproc_model (
   input  wire logic clk,
   input  wire logic nmi_go,
   input  wire logic busy_on,
   input  wire logic err_on,
   input  wire logic req_on,
   output logic      nonmaskable_irq,
   output logic      busy_n,
   output logic      error_n,
   output logic      ext_operand_req
);
   int lvl_cnt = 0;

   initial begin
      nonmaskable_irq = 1'b0;
      busy_n = 1'b1;
      error_n = 1'b1;
      ext_operand_req = 1'b0;
   end

   // nmi kept low at least five cycles before a rise, then high six
   always @(negedge clk) begin
      if (!nonmaskable_irq && nmi_go && lvl_cnt >= 4) begin
         nonmaskable_irq <= 1'b1;
         lvl_cnt <= 0;
      end else if (nonmaskable_irq && lvl_cnt >= 5) begin
         nonmaskable_irq <= 1'b0;
         lvl_cnt <= 0;
      end else begin
         lvl_cnt <= lvl_cnt + 1;
      end
   end

   // busy and error rest high, as the pull-ups would leave them; the request rests low
   always @(negedge clk) begin
      busy_n <= !busy_on;
      error_n <= !err_on;
      ext_operand_req <= req_on;
   end
endmodule : coproc_model

/* dv/cpu_control_input_logic_tb.sv */
// self-checking bench for the processor control-input logic
`timescale 1ns/1ps
module cpu_control_input_logic_tb;
   import cpu_ctl_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, sys_reset = 1'b1;
   logic        hold_req = 1'b0, nmi_go = 1'b0, busy_on = 1'b0;
   logic        err_on = 1'b0, req_on = 1'b0, core_nmi_ack = 1'b0;
   logic        core_op_active = 1'b0, core_wait_exec = 1'b0;
   logic        core_data_drive = 1'b0, nmi_prev = 1'b0, err_prev = 1'b0;
   logic [15:0] core_data = 16'h0000;
   logic [31:0] seed = 32'h00013bde;
   core_bus_t   core_bus = '0;
   core_bus_t   pin_bus;
   logic        nonmaskable_irq, busy_n, error_n, ext_operand_req;
   logic        bus_oe, data_oe, hold_ack, ext_operand_ack_n, op_xfer_req;
   logic        nmi_pending, exec_stall, pext_err_irq, core_enable;
   logic        first_fetch, proc_clk, ph;
   logic [15:0] data_out;
   logic [7:0]  nmi_vector;
   logic [31:0] exp_q[$];
   logic [31:0] note, ev;
   int          err_total = 0, samples_checked = 0, cyc_cnt = 0;

   always #12.5 clk = ~clk;

   cpu_control_input_logic u_dut (.clk(clk), .rst_n(rst_n),
      .sys_reset(sys_reset), .nonmaskable_irq(nonmaskable_irq),
      .hold_req(hold_req), .ext_operand_req(ext_operand_req),
      .busy_n(busy_n), .error_n(error_n), .core_bus(core_bus),
      .core_data(core_data), .core_data_drive(core_data_drive),
      .core_nmi_ack(core_nmi_ack), .core_op_active(core_op_active),
      .core_wait_exec(core_wait_exec), .pin_bus(pin_bus), .bus_oe(bus_oe),
      .data_out(data_out), .data_oe(data_oe), .hold_ack(hold_ack),
      .ext_operand_ack_n(ext_operand_ack_n), .op_xfer_req(op_xfer_req),
      .nmi_pending(nmi_pending), .nmi_vector(nmi_vector),
      .exec_stall(exec_stall), .pext_err_irq(pext_err_irq),
      .core_enable(core_enable), .first_fetch(first_fetch),
      .proc_clk(proc_clk));

   coproc_model u_far (.clk(clk), .nmi_go(nmi_go), .busy_on(busy_on),
      .err_on(err_on), .req_on(req_on), .nonmaskable_irq(nonmaskable_irq),
      .busy_n(busy_n), .error_n(error_n),
      .ext_operand_req(ext_operand_req));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic fail(input string msg);
      err_total++;
      $display("ERROR %0t: %s", $time, msg);
   endtask : fail

   task automatic chk(input bit ok, input string msg);
      samples_checked++;
      if (!ok) fail(msg);
   endtask : chk

   task automatic wait_lvl(ref logic s, input logic v, input int n);
      for (int i = 0; i < n && s !== v; i++) @(negedge clk);
      chk(s === v, "bounded wait ran out");
      if (s !== v) finish_test();
   endtask : wait_lvl

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // first fetch due two sync edges, one state edge, then init
   task automatic drop_reset();
      exp_q.push_back({8'h01, 24'(cyc_cnt + 3 + INIT_CYC)});
      sys_reset = 1'b0;
      wait_lvl(core_enable, 1'b1, 60);
   endtask : drop_reset

   task automatic fire_nmi();
      exp_q.push_back({8'h02, 24'h000002});
      nmi_go <= 1'b1;
      wait_lvl(nonmaskable_irq, 1'b1, 12);
      nmi_go <= 1'b0;
      wait_lvl(nmi_pending, 1'b1, 6);
   endtask : fire_nmi

   task automatic ack_nmi();
      core_nmi_ack = 1'b1;
      @(negedge clk);
      core_nmi_ack = 1'b0;
      repeat (2) @(negedge clk);
      chk(nmi_pending === 1'b0, "nmi not cleared");
   endtask : ack_nmi

   task automatic reset_pins();
      chk(pin_bus === BUS_RESET && ext_operand_ack_n === 1'b1, "pins");
      chk(data_oe === 1'b0 && core_enable === 1'b0, "data float");
   endtask : reset_pins

   // monitor: each cycle with an event at the outputs retires the oldest note
   always @(posedge clk) begin
      #1;
      cyc_cnt++;
      ev = 32'h00000000;
      if (first_fetch === 1'b1) ev = {8'h01, 24'(cyc_cnt)};
      if (nmi_pending === 1'b1 && !nmi_prev) ev = {8'h02, 16'h0, nmi_vector};
      if (pext_err_irq === 1'b1 && !err_prev) ev = {8'h03, 24'h000000};
      nmi_prev = (nmi_pending === 1'b1);
      err_prev = (pext_err_irq === 1'b1);
      if (ev[31:24] != 8'h00) begin
         if (exp_q.size() == 0) fail("unexpected event");
         else begin
            note = exp_q.pop_front();
            samples_checked++;
            if (note[31:24] !== ev[31:24] || (note[31:24] == 8'h01 ?
                (ev[23:0] + 3 < note[23:0] || ev[23:0] > note[23:0] + 3) :
                note[23:0] !== ev[23:0]))
               fail("event differs from note");
         end
      end
   end

   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      core_data_drive = 1'b1;
      repeat (6) @(negedge clk);
      reset_pins();
      chk(bus_oe === 1'b1 && hold_ack === 1'b0, "hold in reset");
      hold_req = 1'b1;
      wait_lvl(hold_ack, 1'b1, 6);
      hold_req = 1'b0;
      repeat (16) @(negedge clk);
      drop_reset();
      $display("test power_on done");
      // short pulse only forces pins, no reinitialisation
      sys_reset = 1'b1;
      repeat (10) @(negedge clk);
      sys_reset = 1'b0;
      wait_lvl(core_enable, 1'b1, 60);
      repeat (50) @(negedge clk);
      sys_reset = 1'b1;
      // synced rise after two edges, clock forced low two edges later
      repeat (4) @(negedge clk);
      chk(proc_clk === 1'b0, "phase not aligned");
      @(negedge clk);
      chk(proc_clk === 1'b1, "phase not resumed");
      repeat (15) @(negedge clk);
      reset_pins();
      drop_reset();
      $display("test reinit done");
      ph = proc_clk;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         chk(proc_clk !== ph, "proc clock stuck");
         ph = proc_clk;
      end
      for (int i = 0; i < 8; i++) begin
         core_bus = core_bus_t'(30'(rnd()));
         core_data = 16'(rnd());
         core_data_drive = rnd() > 32'h7fffffff;
         repeat (3) @(negedge clk);
         chk(pin_bus === core_bus && data_out === core_data, "bus copy");
         chk(data_oe === core_data_drive && bus_oe === 1'b1, "oe");
      end
      core_data_drive = 1'b1;
      hold_req = 1'b1;
      wait_lvl(hold_ack, 1'b1, 6);
      chk(bus_oe === 1'b0 && data_oe === 1'b0, "float in hold");
      hold_req = 1'b0;
      $display("test bus done");
      fire_nmi();
      ack_nmi();
      core_wait_exec = 1'b1;
      busy_on <= 1'b1;
      wait_lvl(exec_stall, 1'b1, 6);
      fire_nmi();
      chk(exec_stall === 1'b0, "nmi blocked in stall");
      ack_nmi();
      chk(exec_stall === 1'b1, "stall lost");
      busy_on <= 1'b0;
      wait_lvl(exec_stall, 1'b0, 6);
      exp_q.push_back({8'h03, 24'h000000});
      err_on <= 1'b1;
      @(negedge clk);
      err_on <= 1'b0;
      repeat (8) @(negedge clk);
      core_wait_exec = 1'b0;
      $display("test coprocessor done");
      req_on <= 1'b1;
      wait_lvl(op_xfer_req, 1'b1, 6);
      core_op_active = 1'b1;
      repeat (2) @(negedge clk);
      chk(ext_operand_ack_n === 1'b0, "ack not low");
      core_op_active = 1'b0;
      req_on <= 1'b0;
      repeat (2) @(negedge clk);
      chk(ext_operand_ack_n === 1'b1, "ack stuck");
      $display("test operand done");
      chk(exp_q.size() == 0, "events missing");
      finish_test();
   end
endmodule : cpu_control_input_logic_tb
